/* File: tb/itac_host_model.sv */
`timescale 1ns/1ps
module itac_host_model
  import itac_pkg::*;
(
  // clock
  input  wire logic                  clk_sys,
  // host bus
  output logic                       dev_sel_n,
  output logic                       rd_n,
  output logic                       wr_n,
  output logic [1:0]                 port_select,
  output logic [ITAC_BUS_W-1:0]      bus_data_lines_i,
  input  wire logic [ITAC_BUS_W-1:0] bus_data_lines_o,
  input  wire logic                  bus_data_lines_oe
);
  import itac_pkg::*;

  initial
  begin
    dev_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select = 2'h0;
    bus_data_lines_i = 8'h5a;
  end

  // one bus cycle held over two edges; sel_n high makes an access to be ignored
  task automatic access(input logic sel_n, input logic wr, input logic [1:0] port,
                        input logic [7:0] wdata, output logic [7:0] rdata, output logic oe);
    @(negedge clk_sys);
    dev_sel_n = sel_n;
    port_select = port;
    rd_n = wr;
    wr_n = !wr;
    if (wr)
    begin
      bus_data_lines_i = wdata;
    end
    @(posedge clk_sys);
    @(posedge clk_sys);
    @(negedge clk_sys);
    rdata = bus_data_lines_o;
    oe = bus_data_lines_oe;
    dev_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    // released bus must not keep showing the last byte
    bus_data_lines_i = ~bus_data_lines_i;
    @(negedge clk_sys);
  endtask
endmodule // itac_host_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import itac_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       dev_sel_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] port_select;
  logic [7:0] bus_data_lines_i;
  logic [7:0] bus_data_lines_o;
  logic       bus_data_lines_oe;
  logic [2:0] cnt_clk = 3'h0;
  logic [2:0] cnt_gate = 3'h7;
  logic [2:0] cnt_out;
  logic [7:0] rdata;
  logic       oe_seen;
  int         miscompares = 0;
  int         num_checks = 0;

  always #2 clk_sys = ~clk_sys;

  itac_core u_itac_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .dev_sel_n(dev_sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select(port_select), .bus_data_lines_i(bus_data_lines_i),
    .bus_data_lines_o(bus_data_lines_o), .bus_data_lines_oe(bus_data_lines_oe),
    .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out));

  itac_host_model u_itac_host_model (
    .clk_sys(clk_sys), .dev_sel_n(dev_sel_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select(port_select), .bus_data_lines_i(bus_data_lines_i),
    .bus_data_lines_o(bus_data_lines_o), .bus_data_lines_oe(bus_data_lines_oe));

  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] port, input logic [7:0] d);
    u_itac_host_model.access(1'b0, 1'b1, port, d, rdata, oe_seen);
  endtask

  // read; oe_exp low means the read must be refused
  task automatic rd(input logic [1:0] port, input logic [7:0] exp, input logic oe_exp);
    u_itac_host_model.access(1'b0, 1'b0, port, 8'h00, rdata, oe_seen);
    chk({7'h0, oe_exp}, {7'h0, oe_seen});
    if (oe_exp)
    begin
      chk(exp, rdata);
    end
    chk(8'h00, {7'h0, bus_data_lines_oe});
  endtask

  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n)
    begin
      @(negedge clk_sys);
      cnt_clk = m;
      repeat (3) @(negedge clk_sys);
      cnt_clk = 3'h0;
      repeat (3) @(negedge clk_sys);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial
  begin
    #40000;
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(2'h3, 8'h00, 1'b0);
    u_itac_host_model.access(1'b1, 1'b0, 2'h0, 8'h00, rdata, oe_seen);
    chk(8'h00, {7'h0, oe_seen});
    $display("test 1 done");
    wr(2'h3, 8'h30);
    wr(2'h0, 8'h34);
    wr(2'h0, 8'h12);
    pulse(3'h1, 1);
    rd(2'h0, 8'h34, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    pulse(3'h1, 1);
    rd(2'h0, 8'h33, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    $display("test 2 done");
    u_itac_host_model.access(1'b1, 1'b1, 2'h3, 8'h00, rdata, oe_seen);
    pulse(3'h1, 1);
    rd(2'h0, 8'h32, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    wr(2'h3, 8'h00);
    pulse(3'h1, 2);
    rd(2'h0, 8'h32, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    rd(2'h0, 8'h30, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    $display("test 3 done");
    wr(2'h3, 8'h50);
    wr(2'h3, 8'ha0);
    wr(2'h1, 8'h07);
    wr(2'h2, 8'h05);
    pulse(3'h6, 1);
    rd(2'h1, 8'h07, 1'b1);
    rd(2'h2, 8'h05, 1'b1);
    rd(2'h0, 8'h30, 1'b1);
    rd(2'h0, 8'h12, 1'b1);
    $display("test 4 done");
    wr(2'h3, 8'h51);
    wr(2'h1, 8'h10);
    pulse(3'h2, 2);
    rd(2'h1, 8'h09, 1'b1);
    chk(8'h00, {7'h0, cnt_out[1]});
    pulse(3'h2, 9);
    chk(8'h01, {7'h0, cnt_out[1]});
    $display("test 5 done");
    // one-shot mode: the count loads only after a gate rise seen on a count clock rise
    wr(2'h3, 8'h92);
    wr(2'h2, 8'h03);
    pulse(3'h4, 1);
    rd(2'h2, 8'h00, 1'b1);
    cnt_gate = 3'h3;
    pulse(3'h4, 1);
    cnt_gate = 3'h7;
    pulse(3'h4, 1);
    rd(2'h2, 8'h03, 1'b1);
    chk(8'h00, {7'h0, cnt_out[2]});
    pulse(3'h4, 3);
    chk(8'h01, {7'h0, cnt_out[2]});
    chk(8'h00, {7'h0, cnt_out[0]});
    $display("test 6 done");
    final_report();
  end
endmodule // tb

/* File: verilog/itac_bus_decode.sv */
`timescale 1ns/1ps
module itac_bus_decode
  import itac_pkg::*;
(
  // host strobes
  input  wire logic       dev_sel_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [1:0] port_select,
  // decoded
  output logic [ITAC_NUM_CNT-1:0] cnt_sel,
  output logic                    ctrl_sel,
  output logic                    rd_act,
  output logic                    wr_act
);
  always_comb
  begin
    rd_act   = !dev_sel_n && !rd_n && wr_n;  // [R02] [R03]
    wr_act   = !dev_sel_n && !wr_n && rd_n;  // [R02] [R03]
    cnt_sel  = '0;
    ctrl_sel = 1'b0;
    unique case (port_select)  // [R01]
      ITAC_PORT_CNT0: cnt_sel[0] = 1'b1;
      ITAC_PORT_CNT1: cnt_sel[1] = 1'b1;
      ITAC_PORT_CNT2: cnt_sel[2] = 1'b1;
      ITAC_PORT_CTRL: ctrl_sel   = 1'b1;
    endcase
  end
endmodule // itac_bus_decode

/* File: verilog/itac_core.sv */
`timescale 1ns/1ps
// Overview of operation
// R01 - port select reaches three counters or control
// R02 - strobes ignored unless device select low
// R03 - read low reads, write low writes
// R04 - port three write stores control word
// R05 - control word cannot be read back
// R06 - three identical independent counters
// R07 - sixteen bit presettable down counter
// R08 - output latch follows count, freezes until read
// R09 - one latch half drives bus at once
// R10 - reads return output latch, never counter
// R11 - status holds control word, output, null
// R12 - modes one and five sample gate rising
// R13 - binary or bcd counting selectable
// R14 - data bus driven only on selected reads
// R15 - count bytes staged, cleared on programming
// R16 - host writes control word before count
// R17 - latch command freezes selected counter count
module itac_core
  import itac_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // host bus
  input  wire logic                    dev_sel_n,
  input  wire logic                    rd_n,
  input  wire logic                    wr_n,
  input  wire logic [1:0]              port_select,
  input  wire logic [ITAC_BUS_W-1:0]   bus_data_lines_i,
  output logic      [ITAC_BUS_W-1:0]   bus_data_lines_o,
  output logic                         bus_data_lines_oe,
  // counter pins
  input  wire logic [ITAC_NUM_CNT-1:0] cnt_clk,
  input  wire logic [ITAC_NUM_CNT-1:0] cnt_gate,
  output logic      [ITAC_NUM_CNT-1:0] cnt_out
);
  import itac_pkg::*;
  logic [ITAC_NUM_CNT-1:0] cnt_sel;
  logic                    ctrl_sel, rd_act, wr_act, rd_q, wr_q, rd_stb, wr_stb;
  logic [7:0]              mode_setup_word_q;
  logic [ITAC_NUM_CNT-1:0] prog_stb, latch_stb, cwr_stb, crd_stb;
  logic [7:0]              rd_byte [ITAC_NUM_CNT];
  logic [7:0]              status_byte [ITAC_NUM_CNT];
  logic [7:0]              dout_q;
  logic [1:0]              sc;

  itac_bus_decode u_dec (
    .dev_sel_n   (dev_sel_n),
    .rd_n        (rd_n),
    .wr_n        (wr_n),
    .port_select (port_select),
    .cnt_sel     (cnt_sel),
    .ctrl_sel    (ctrl_sel),
    .rd_act      (rd_act),
    .wr_act      (wr_act)
  );

  // one action per strobe: act on the leading edge of the access
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
    else
    begin
      rd_q <= rd_act;
      wr_q <= wr_act;
    end
  end
  assign rd_stb = rd_act && !rd_q;
  assign wr_stb = wr_act && !wr_q;
  assign sc = bus_data_lines_i[ITAC_CW_SC_HI:ITAC_CW_SC_LO];

  // write-only control register, no read path exists
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_setup_word_q <= ITAC_CW_RESET;
    else if (wr_stb && ctrl_sel &&
             bus_data_lines_i[ITAC_CW_RW_HI:ITAC_CW_RW_LO] != ITAC_RW_LATCH)
      mode_setup_word_q <= bus_data_lines_i;  // [R04] [R05]
  end

  genvar g;
  generate
    for (g = 0; g < ITAC_NUM_CNT; g++)
    begin : g_cnt
      assign prog_stb[g]  = wr_stb && ctrl_sel && sc == 2'(g) &&
                            bus_data_lines_i[ITAC_CW_RW_HI:ITAC_CW_RW_LO] != ITAC_RW_LATCH;  // [R04]
      assign latch_stb[g] = wr_stb && ctrl_sel && sc == 2'(g) &&
                            bus_data_lines_i[ITAC_CW_RW_HI:ITAC_CW_RW_LO] == ITAC_RW_LATCH;  // [R17]
      assign cwr_stb[g]   = wr_stb && cnt_sel[g];  // [R01]
      assign crd_stb[g]   = rd_stb && cnt_sel[g];  // [R01]
      itac_counter #(.W(ITAC_CNT_W)) u_cnt (  // [R06]
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .prog_stb    (prog_stb[g]),
        .prog_word   (bus_data_lines_i),
        .latch_stb   (latch_stb[g]),
        .wr_stb      (cwr_stb[g]),
        .rd_stb      (crd_stb[g]),
        .wr_data     (bus_data_lines_i),
        .cnt_clk     (cnt_clk[g]),
        .gate        (cnt_gate[g]),
        .cnt_out     (cnt_out[g]),
        .rd_byte     (rd_byte[g]),
        .status_byte (status_byte[g])
      );
    end
  endgenerate

  // read data registered at the start of the read and held through it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      dout_q <= '0;
    else if (rd_stb)
    begin
      dout_q <= '0;
      for (int i = 0; i < ITAC_NUM_CNT; i++)
        if (cnt_sel[i]) dout_q <= rd_byte[i];  // [R10]
    end
  end
  assign bus_data_lines_o  = dout_q;
  assign bus_data_lines_oe = rd_q && rd_act && !ctrl_sel;  // [R14]

  // checks
  a_ignore_unsel: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R02]
    dev_sel_n |-> !rd_stb && !wr_stb && !bus_data_lines_oe)
    else $error("strobe acted while deselected");
  a_oe_read_only: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R14]
    bus_data_lines_oe |-> !rd_n && !dev_sel_n && !$past(rd_n))
    else $error("bus driven outside a read");
  a_ctrl_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R05]
    ctrl_sel |-> !bus_data_lines_oe)
    else $error("control word driven on bus");
  a_cw_store: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R04]
    (wr_stb && ctrl_sel && bus_data_lines_i[ITAC_CW_RW_HI:ITAC_CW_RW_LO] != ITAC_RW_LATCH) |=>
      mode_setup_word_q == $past(bus_data_lines_i))
    else $error("control word not stored");
  a_decode_map: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R01]
    $onehot({ctrl_sel, cnt_sel}) && (ctrl_sel == (port_select == ITAC_PORT_CTRL)))
    else $error("port decode wrong");
  a_latch_no_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R17]
    (wr_stb && ctrl_sel && bus_data_lines_i[ITAC_CW_RW_HI:ITAC_CW_RW_LO] == ITAC_RW_LATCH) |=>
      $stable(mode_setup_word_q))
    else $error("latch command changed control word");
  a_rd_data: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R10]
    (rd_stb && cnt_sel[0]) |=> dout_q == $past(rd_byte[0]))
    else $error("read data not from latch");
  a_write_level: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R03]
    wr_stb |-> !wr_n && rd_n ##1 !wr_stb)
    else $error("write strobe misdecoded");
  // status must carry bits 5:0 of the new word, the output level and a set null flag
  a_status_prog: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [R11]
    prog_stb[0] |=>
      status_byte[0] == {cnt_out[0], 1'b1, mode_setup_word_q[ITAC_CW_RW_HI:0]})
    else $error("status does not reflect programming");
endmodule // itac_core

/* File: verilog/itac_counter.sv */
`timescale 1ns/1ps
module itac_counter
  import itac_pkg::*;
#(
  parameter int W = ITAC_CNT_W
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // programming
  input  wire logic        prog_stb,
  input  wire logic [7:0]  prog_word,
  input  wire logic        latch_stb,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [7:0]  wr_data,
  // counter pins
  input  wire logic        cnt_clk,
  input  wire logic        gate,
  output logic             cnt_out,
  // read side
  output logic [7:0]       rd_byte,
  output logic [7:0]       status_byte
);
  import itac_pkg::*;
  typedef enum logic [1:0] {ITAC_CS_IDLE, ITAC_CS_LOADED, ITAC_CS_RUN} itac_cstate_t;
  itac_cstate_t st_q;
  logic [7:0]   cw_q;
  logic [W-1:0] count_load_register_q, ce_q, output_latch_q;
  logic         latched_q, wr_hi_q, rd_hi_q, null_q, clk_q, trig_q, out_q;
  logic         clk_rise, wr_done;
  logic [W-1:0] ce_dec;
  logic [1:0]   fmt;
  logic [2:0]   mode;
  assign fmt  = cw_q[ITAC_CW_RW_HI:ITAC_CW_RW_LO];
  assign mode = cw_q[ITAC_CW_M_HI:ITAC_CW_M_LO];
  assign clk_rise = cnt_clk && !clk_q;
  assign wr_done = wr_stb && (fmt != ITAC_RW_BOTH || wr_hi_q);
  // binary or bcd decrement
  always_comb
  begin
    ce_dec = ce_q - W'(1);
    if (cw_q[ITAC_CW_BCD])  // [R13]
    begin
      ce_dec = ce_q;
      for (int i = 0; i < W/4; i++)
      begin
        if (ce_dec[i*4 +: 4] != 4'h0)
        begin
          ce_dec[i*4 +: 4] = ce_dec[i*4 +: 4] - 4'h1;
          break;
        end
        ce_dec[i*4 +: 4] = ITAC_BCD_MAX;
      end
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cw_q <= ITAC_CW_RESET;
      count_load_register_q <= '0;
      wr_hi_q <= 1'b0;
    end
    else if (prog_stb)
    begin
      cw_q <= prog_word;
      count_load_register_q <= '0;  // [R15]
      wr_hi_q <= 1'b0;
    end
    else if (wr_stb)
    begin
      unique case (fmt)  // [R16]
        ITAC_RW_MSB: count_load_register_q[W-1:8] <= wr_data;
        ITAC_RW_BOTH:
          if (wr_hi_q) count_load_register_q[W-1:8] <= wr_data;
          else count_load_register_q[7:0] <= wr_data;
        default: count_load_register_q[7:0] <= wr_data;
      endcase
      wr_hi_q <= (fmt == ITAC_RW_BOTH) && !wr_hi_q;
    end
  end
  // counting element: down counter preset from the load register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= ITAC_CS_IDLE;
      ce_q <= '0;
      null_q <= 1'b1;
      clk_q <= 1'b0;
      trig_q <= 1'b0;
      out_q <= 1'b0;
    end
    else
    begin
      clk_q <= cnt_clk;
      if (clk_rise) trig_q <= gate;  // [R12]
      if (prog_stb)
      begin
        st_q <= ITAC_CS_IDLE;
        null_q <= 1'b1;
        out_q <= 1'b0;
      end
      else if (wr_done)
      begin
        st_q <= ITAC_CS_LOADED;
        null_q <= 1'b1;
      end
      else if (clk_rise)
      begin
        unique case (st_q)
          ITAC_CS_IDLE: ;
          ITAC_CS_LOADED:
            if (!(mode == ITAC_MODE_ONESHOT || mode == ITAC_MODE_HWSTROBE) ||
                (gate && !trig_q))  // [R12]
            begin
              ce_q <= {count_load_register_q[W-1:8], count_load_register_q[7:0]};  // [R07] [R15]
              null_q <= 1'b0;
              st_q <= ITAC_CS_RUN;
            end
          ITAC_CS_RUN:
            if (gate)
            begin
              ce_q <= ce_dec;  // [R07]
              if (ce_q == W'(1)) out_q <= 1'b1;
            end
        endcase
      end
    end
  end
  assign cnt_out = out_q;
  // output latch follows the ce until a latch command freezes it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      output_latch_q <= '0;
      latched_q <= 1'b0;
      rd_hi_q <= 1'b0;
    end
    else
    begin
      if (latch_stb && !latched_q)
        latched_q <= 1'b1;  // [R17]
      else if (rd_stb && (fmt != ITAC_RW_BOTH || rd_hi_q))
        latched_q <= 1'b0;  // [R08]
      if (!latched_q && !(latch_stb && latched_q))
        output_latch_q <= ce_q;  // [R08]
      if (prog_stb) rd_hi_q <= 1'b0;
      else if (rd_stb) rd_hi_q <= (fmt == ITAC_RW_BOTH) && !rd_hi_q;
    end
  end
  // one half at a time onto the byte path, never the ce itself
  always_comb
  begin
    if (fmt == ITAC_RW_MSB || (fmt == ITAC_RW_BOTH && rd_hi_q))
      rd_byte = output_latch_q[W-1:8];  // [R09] [R10]
    else
      rd_byte = output_latch_q[7:0];  // [R09] [R10]
  end
  assign status_byte = {out_q, null_q, cw_q[ITAC_CW_RW_HI:0]};  // [R11]
endmodule // itac_counter

/* File: verilog/itac_pkg.sv */
package itac_pkg;
  // port select codes
  localparam logic [1:0] ITAC_PORT_CNT0 = 2'h0;
  localparam logic [1:0] ITAC_PORT_CNT1 = 2'h1;
  localparam logic [1:0] ITAC_PORT_CNT2 = 2'h2;
  localparam logic [1:0] ITAC_PORT_CTRL = 2'h3;
  // control word fields
  localparam int ITAC_CW_SC_HI = 7;
  localparam int ITAC_CW_SC_LO = 6;
  localparam int ITAC_CW_RW_HI = 5;
  localparam int ITAC_CW_RW_LO = 4;
  localparam int ITAC_CW_M_HI  = 3;
  localparam int ITAC_CW_M_LO  = 1;
  localparam int ITAC_CW_BCD   = 0;
  // access formats in bits 5:4
  localparam logic [1:0] ITAC_RW_LATCH = 2'h0;
  localparam logic [1:0] ITAC_RW_LSB   = 2'h1;
  localparam logic [1:0] ITAC_RW_MSB   = 2'h2;
  localparam logic [1:0] ITAC_RW_BOTH  = 2'h3;
  localparam logic [1:0] ITAC_SC_READBACK = 2'h3;
  // modes that use gate triggers
  localparam logic [2:0] ITAC_MODE_ONESHOT = 3'h1;
  localparam logic [2:0] ITAC_MODE_HWSTROBE = 3'h5;
  localparam logic [7:0] ITAC_CW_RESET = 8'h00;
  localparam int ITAC_NUM_CNT = 3;
  localparam int ITAC_CNT_W   = 16;
  localparam int ITAC_BUS_W   = 8;
  localparam logic [3:0] ITAC_BCD_MAX = 4'h9;
endpackage
